// ### rtl/psrc_regs.vh
// register offsets, field positions and reset values of the slot status / root control bank
`ifndef PSRC_REGS_VH
`define PSRC_REGS_VH

// =====================================================================
// configuration space offsets (byte addresses, 16-bit registers)
`define PSRC_ADDR_W             8
`define PSRC_OFF_SLOT_STATUS    8'hba
`define PSRC_OFF_ROOT_CONTROL   8'hbc

// =====================================================================
// slot_event_status fields
`define PSRC_SS_BUTTON          0
`define PSRC_SS_FAULT           1
`define PSRC_SS_LATCH           2
`define PSRC_SS_PRESENCE_CHG    3
`define PSRC_SS_PRESENCE        6
`define PSRC_SS_RESET           16'h0000

// =====================================================================
// root_port_error_control fields
`define PSRC_RC_CORR            0
`define PSRC_RC_NONFATAL        1
`define PSRC_RC_FATAL           2
`define PSRC_RC_WAKE            3
`define PSRC_RC_WMASK           16'h000f
`define PSRC_RC_RESET           16'h0000

// =====================================================================
// slot control bit read for notification
`define PSRC_SC_PRESENCE_NOTIFY 3

`endif

// ### rtl/psrc_sync.v
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module psrc_sync #(
    parameter W = 1                         // number of bits
) (
    input  wire         i_clk,              // core clock
    input  wire         i_rst_n,            // async reset, active low
    input  wire         i_ce,               // clock enable
    input  wire [W-1:0] i_async,            // raw pin levels
    output wire [W-1:0] o_sync              // synchronised levels
);

    // =================================================================
    // synchroniser chain
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg stage1;                     // metastable stage, read only by stage2
            reg stage2;                     // clean stage
            // one chain per bit, keeps bits independent
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else if (i_ce) begin
                    stage1 <= i_async[g];
                    stage2 <= stage1;
                end
            end
            assign o_sync[g] = stage2;
        end
    endgenerate

endmodule

`default_nettype wire

// ### rtl/psrc_bank.v
// slot status and root control register bank of a root port
// Operation
// - presence is OR of inband and outofband
// - no slot: presence always reads one
// - inband presence counts only while powered
// - presence change sets changed flag
// - latch sensor change sets bit two
// - power fault sets bit one
// - button press sets bit zero
// - wake enable gates interrupt on wake message
// - enable rising while status set interrupts
// - fatal enable gates system error
// - nonfatal enable gates system error
// - correctable enable gates system error
// - enables cover own and received errors
// - root enables override command register enable
// - presence notify needs slot control enable
`timescale 1ns/100ps
`default_nettype none
`include "psrc_regs.vh"

module psrc_bank #(
    parameter SLOT_IMPL    = 1,             // port drives a physical slot
    parameter LATCH_IMPL   = 1,             // retention latch sensor fitted
    parameter FAULT_IMPL   = 1,             // power fault detection fitted
    parameter BUTTON_IMPL  = 1              // attention button fitted
) (
    input  wire                     i_clk,              // core clock, 50 MHz
    input  wire                     i_rst_n,            // async reset, active low
    input  wire                     i_ce,               // clock enable, freezes all state
    // configuration access
    input  wire [`PSRC_ADDR_W-1:0]  i_cfg_addr,         // byte offset of the register
    input  wire                     i_cfg_wr,           // write strobe, one cycle
    input  wire                     i_cfg_rd,           // read strobe, one cycle
    input  wire [15:0]              i_cfg_wdata,        // write data
    input  wire [1:0]               i_cfg_be,           // byte enables
    output reg  [15:0]              o_cfg_rdata,        // read data, one cycle after strobe
    output reg                      o_cfg_rvalid,       // read data valid pulse
    // slot pins (asynchronous)
    input  wire                     i_oob_presence,     // out-of-band presence detect
    input  wire                     i_retention_latch,  // latch sensor level
    input  wire                     i_power_fault,      // power controller fault level
    input  wire                     i_button_n,         // attention button, active low
    // core-side status (same clock)
    input  wire                     i_link_presence,    // in-band presence from phy
    input  wire                     i_slot_powered,     // adapter power applied
    input  wire                     i_presence_notify_enable, // slot control enable bit
    input  wire                     i_wake_status,      // pme status of root status
    input  wire                     i_wake_msg,         // pme message received, pulse
    input  wire                     i_err_fatal,        // fatal error, own or received
    input  wire                     i_err_nonfatal,     // non-fatal error, own or received
    input  wire                     i_err_correctable,  // correctable error, own or received
    // outputs
    output reg                      o_presence_notify,  // software notification pulse
    output reg                      o_wake_interrupt,   // pme interrupt pulse
    output reg                      o_syserr            // system error pulse
);

    // =================================================================
    // pin synchronisation
    localparam NPIN = 4;                    // synchronised pins
    wire [NPIN-1:0] pin_sync;               // synchronised pin levels

    // pins come from connector and
    // power controller: two flops each
    // before any logic reads them
    // button inverted ahead of the chain:
    // a zeroed chain reads as released,
    // so no false press after reset
    psrc_sync #(
        .W (NPIN)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_async ({~i_button_n, i_power_fault, i_retention_latch, i_oob_presence}),
        .o_sync  (pin_sync)
    );

    // taps, in vector order: presence,
    // latch, fault, button
    wire oob_presence = pin_sync[0];        // out-of-band presence
    wire latch_level  = pin_sync[1];        // latch sensor
    wire fault_level  = pin_sync[2];        // power fault
    wire button_level = pin_sync[3];        // button held

    // =================================================================
    // state
    reg        presence_q;                  // last reported presence
    reg        presence_valid;              // first sample taken since reset
    reg        latch_q;                     // last latch level
    reg        fault_q;                     // last fault level
    reg        button_q;                    // last button level
    reg        presence_changed_flag;       // status bit 3
    reg        latch_sensor_changed_flag;   // status bit 2
    reg        power_fault_flag;            // status bit 1
    reg        button_pressed_flag;         // status bit 0
    reg        wake_interrupt_enable;       // control bit 3
    reg        syserr_on_fatal_enable;      // control bit 2
    reg        syserr_on_nonfatal_enable;   // control bit 1
    reg        syserr_on_correctable_enable;// control bit 0

    // history regs keep last view;
    // an event is a difference from
    // the live source

    // =================================================================
    // address decode, used for both reads and writes
    // full offset compare: no unmapped
    // offset aliases onto the bank
    // one function serves both paths
    function hit;
        input [`PSRC_ADDR_W-1:0] addr;
        input [`PSRC_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // live bits sit in the low byte;
    // a write without it does nothing
    // write-one-to-clear on the low byte of slot status
    wire ss_wr   = i_cfg_wr && hit(i_cfg_addr, `PSRC_OFF_SLOT_STATUS) && i_cfg_be[0];
    wire rc_wr   = i_cfg_wr && hit(i_cfg_addr, `PSRC_OFF_ROOT_CONTROL) && i_cfg_be[0];

    // =================================================================
    // presence: in-band only trusted while powered
    // an unpowered card cannot train
    // its link; the out-of-band pin
    // still sees it seated
    // a port with no slot reads one
    // bit 6 is the live value
    wire inband_presence = i_link_presence & i_slot_powered;
    wire adapter_presence = (SLOT_IMPL == 0) ? 1'b1 :
                            (inband_presence | oob_presence);

    // fault and button take rising
    // edges: a held level sets once;
    // the latch takes both directions
    // change events; first sample after reset only seeds the history
    wire presence_event = presence_valid && (adapter_presence != presence_q);
    wire latch_event    = (LATCH_IMPL != 0) && presence_valid &&
                          (latch_level != latch_q);
    wire fault_event    = (FAULT_IMPL != 0) && fault_level && !fault_q;
    wire button_event   = (BUTTON_IMPL != 0) && button_level && !button_q;

    // clear requests; a set in the same cycle wins
    // a zero bit leaves its flag alone
    wire clr_pchg  = ss_wr && i_cfg_wdata[`PSRC_SS_PRESENCE_CHG];
    wire clr_latch = ss_wr && i_cfg_wdata[`PSRC_SS_LATCH];
    wire clr_fault = ss_wr && i_cfg_wdata[`PSRC_SS_FAULT];
    wire clr_btn   = ss_wr && i_cfg_wdata[`PSRC_SS_BUTTON];

    // =================================================================
    // history and status flags
    // hazard: an event in a clear's
    // cycle must not be lost, so the
    // set branch comes first
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // flags and history clear
            presence_q                <= 1'b0;
            presence_valid            <= 1'b0;
            latch_q                   <= 1'b0;
            fault_q                   <= 1'b0;
            button_q                  <= 1'b0;
            presence_changed_flag     <= 1'b0;
            latch_sensor_changed_flag <= 1'b0;
            power_fault_flag          <= 1'b0;
            button_pressed_flag       <= 1'b0;
        end else if (i_ce) begin
            // history follows its sources
            presence_q     <= adapter_presence;
            presence_valid <= 1'b1;
            latch_q        <= latch_level;
            fault_q        <= fault_level;
            button_q       <= button_level;
            // set beats clear, writing zero changes nothing
            // presence changed, bit 3
            if (presence_event) begin
                presence_changed_flag <= 1'b1;
            end else if (clr_pchg) begin
                presence_changed_flag <= 1'b0;
            end
            // latch changed, bit 2
            if (latch_event) begin
                latch_sensor_changed_flag <= 1'b1;
            end else if (clr_latch) begin
                latch_sensor_changed_flag <= 1'b0;
            end
            // power fault, bit 1
            if (fault_event) begin
                power_fault_flag <= 1'b1;
            end else if (clr_fault) begin
                power_fault_flag <= 1'b0;
            end
            // button pressed, bit 0
            if (button_event) begin
                button_pressed_flag <= 1'b1;
            end else if (clr_btn) begin
                button_pressed_flag <= 1'b0;
            end
        end
    end

    // =================================================================
    // root control register, only bits 3:0 writable
    // bits 15:4 have no storage, so
    // ones written there never read
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // every enable off after reset
            wake_interrupt_enable        <= 1'b0;
            syserr_on_fatal_enable       <= 1'b0;
            syserr_on_nonfatal_enable    <= 1'b0;
            syserr_on_correctable_enable <= 1'b0;
        end else if (i_ce && rc_wr) begin
            // upper bits are reserved and dropped
            wake_interrupt_enable        <= i_cfg_wdata[`PSRC_RC_WAKE];
            syserr_on_fatal_enable       <= i_cfg_wdata[`PSRC_RC_FATAL];
            syserr_on_nonfatal_enable    <= i_cfg_wdata[`PSRC_RC_NONFATAL];
            syserr_on_correctable_enable <= i_cfg_wdata[`PSRC_RC_CORR];
        end
    end

    // =================================================================
    // wake interrupt: on message, or on enable rising over pending status
    // a message needs the stored enable;
    // a rise is judged against the
    // stored enable, so writing one
    // again gives no second pulse
    wire wake_rise = rc_wr && i_cfg_wdata[`PSRC_RC_WAKE] && !wake_interrupt_enable;
    wire next_wake = (wake_interrupt_enable && i_wake_msg) ||
                     (wake_rise && i_wake_status);

    // =================================================================
    // system error: root enables alone decide, command register ignored
    // own and received errors share
    // the three inputs; each class has
    // its own enable
    // the command register has no input
    wire next_syserr = (syserr_on_fatal_enable && i_err_fatal) ||
                       (syserr_on_nonfatal_enable && i_err_nonfatal) ||
                       (syserr_on_correctable_enable && i_err_correctable);

    // notification only for a fresh change with the enable set
    // follows the setting of the flag,
    // so a flag left set raises no more
    wire next_notify = presence_event && i_presence_notify_enable;

    // =================================================================
    // read mux, reserved bits zero
    // combinational decode; only the
    // registered copy leaves the block
    reg [15:0] next_rdata;
    always @* begin
        next_rdata = 16'h0000;
        if (hit(i_cfg_addr, `PSRC_OFF_SLOT_STATUS)) begin
            // slot status view
            next_rdata[`PSRC_SS_PRESENCE]     = adapter_presence;
            next_rdata[`PSRC_SS_PRESENCE_CHG] = presence_changed_flag;
            next_rdata[`PSRC_SS_LATCH]        = latch_sensor_changed_flag;
            next_rdata[`PSRC_SS_FAULT]        = power_fault_flag;
            next_rdata[`PSRC_SS_BUTTON]       = button_pressed_flag;
        end else if (hit(i_cfg_addr, `PSRC_OFF_ROOT_CONTROL)) begin
            // root control view
            next_rdata[`PSRC_RC_WAKE]     = wake_interrupt_enable;
            next_rdata[`PSRC_RC_FATAL]    = syserr_on_fatal_enable;
            next_rdata[`PSRC_RC_NONFATAL] = syserr_on_nonfatal_enable;
            next_rdata[`PSRC_RC_CORR]     = syserr_on_correctable_enable;
        end
        // unmapped offsets read zero
    end

    // =================================================================
    // registered outputs
    // rdata holds until the next read
    // so software may take it late
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // outputs quiet during reset
            o_cfg_rdata       <= `PSRC_SS_RESET;
            o_cfg_rvalid      <= 1'b0;
            o_presence_notify <= 1'b0;
            o_wake_interrupt  <= 1'b0;
            o_syserr          <= 1'b0;
        end else if (i_ce) begin
            o_cfg_rvalid      <= i_cfg_rd;
            if (i_cfg_rd) begin
                o_cfg_rdata <= next_rdata;
            end
            // event pulses, one cycle after the cause; causes in the same cycle share one pulse
            o_presence_notify <= next_notify;
            o_wake_interrupt  <= next_wake;
            o_syserr          <= next_syserr;
        end
    end

endmodule

`default_nettype wire

// ### dv/psrc_monitor.sv
// assertion checker on the ports of the slot status and root control bank
`timescale 1ns/100ps
`default_nettype none
`include "psrc_regs.vh"
module psrc_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic        i_cfg_wr,
    input wire logic        i_cfg_rd,
    input wire logic [15:0] i_cfg_wdata,
    input wire logic [1:0]  i_cfg_be,
    input wire logic [15:0] o_cfg_rdata,
    input wire logic        o_cfg_rvalid,
    input wire logic        i_presence_notify_enable,
    input wire logic        i_wake_status,
    input wire logic        i_wake_msg,
    input wire logic        i_err_fatal,
    input wire logic        i_err_nonfatal,
    input wire logic        i_err_correctable,
    input wire logic        o_presence_notify,
    input wire logic        o_wake_interrupt,
    input wire logic        o_syserr
);
    // ==========================================================
    // shadow of the enables: only a taken low-byte write moves them
    logic [3:0] rc;         // enables as software left them
    logic       rc_wr;      // write to root control taken this edge
    logic       rd_taken;   // read strobe taken this edge
    logic       serr_cause; // some enabled error seen this edge
    logic       wake_cause; // wake message or enable rise this edge
    assign rc_wr = i_ce && i_cfg_wr && i_cfg_be[0] && (i_cfg_addr == `PSRC_OFF_ROOT_CONTROL);
    assign rd_taken = i_ce && i_cfg_rd;
    assign serr_cause = i_ce && ((i_err_fatal && rc[2]) || (i_err_nonfatal && rc[1]) || (i_err_correctable && rc[0]));
    assign wake_cause = i_ce && ((i_wake_msg && rc[3]) || (rc_wr && i_cfg_wdata[3] && !rc[3] && i_wake_status));
    // shadow register, cleared with the design
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rc <= 4'h0;
        end else if (rc_wr) begin
            rc <= i_cfg_wdata[3:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // error gating, wake interrupt, read port and presence notify gate
    a_fatal_gate: assert property (i_ce && i_err_fatal && rc[2] |=> o_syserr)
        else $error("fatal error with enable set gave no system error");
    a_nonfatal_gate: assert property (i_ce && i_err_nonfatal && rc[1] |=> o_syserr)
        else $error("non-fatal error with enable set gave no system error");
    a_corr_gate: assert property (i_ce && i_err_correctable && rc[0] |=> o_syserr)
        else $error("correctable error with enable set gave no system error");
    a_syserr_cause: assert property (o_syserr |-> $past(serr_cause))
        else $error("system error without an enabled cause");
    a_wake_msg: assert property (i_ce && i_wake_msg && rc[3] |=> o_wake_interrupt)
        else $error("wake message with enable set gave no interrupt");
    a_wake_rise: assert property (rc_wr && i_cfg_wdata[3] && !rc[3] && i_wake_status |=> o_wake_interrupt)
        else $error("enable rise with status set gave no interrupt");
    a_wake_cause: assert property (o_wake_interrupt |-> $past(wake_cause))
        else $error("wake interrupt without a cause");
    a_read_answer: assert property (o_cfg_rvalid == $past(rd_taken))
        else $error("read valid not one cycle after the strobe");
    a_reserved_zero: assert property (o_cfg_rvalid |-> (o_cfg_rdata & 16'hff30) == 16'h0000)
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property (rd_taken && i_cfg_addr != 8'hba && i_cfg_addr != 8'hbc
        |=> o_cfg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_rc_readback: assert property (rd_taken && i_cfg_addr == 8'hbc |=> o_cfg_rdata == {12'h000, rc})
        else $error("root control read differs from written enables");
    a_notify_gate: assert property (o_presence_notify |-> $past(i_presence_notify_enable))
        else $error("presence notify while its enable was clear");
endmodule
bind psrc_bank psrc_monitor u_psrc_monitor (.i_clk, .i_rst_n, .i_ce, .i_cfg_addr, .i_cfg_wr, .i_cfg_rd,
    .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .o_cfg_rvalid, .i_presence_notify_enable, .i_wake_status,
    .i_wake_msg, .i_err_fatal, .i_err_nonfatal, .i_err_correctable, .o_presence_notify,
    .o_wake_interrupt, .o_syserr);
`default_nettype wire

// ### dv/psrc_card_model.sv
// behavioural adapter card and slot pins on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module psrc_card_model (
    input  wire logic i_clk,
    output var logic  o_oob_presence,
    output var logic  o_slot_powered,
    output var logic  o_retention_latch,
    output var logic  o_power_fault,
    output var logic  o_button_n,
    output wire logic o_link_presence
);
    logic seated;   // card sits in the connector
    // ==========================================================
    // the link only trains on a powered card, so in-band presence needs power
    assign o_link_presence = seated & o_slot_powered;
    // empty slot, button released
    initial begin
        {seated, o_oob_presence, o_slot_powered, o_retention_latch, o_power_fault, o_button_n} = 6'b000001;
    end
    // pins move just after an edge: seated, oob, power, latch, fault, button_n
    task automatic put(input logic [5:0] v);
        @(posedge i_clk);
        {seated, o_oob_presence, o_slot_powered, o_retention_latch, o_power_fault, o_button_n} <= v;
        repeat (6) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ### dv/psrc_bank_tb.sv
// self-checking bench for the slot status and root control bank
`timescale 1ns/100ps
`default_nettype none
`include "psrc_regs.vh"
module psrc_bank_tb;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
    logic [7:0]  i_cfg_addr = 8'h00;
    logic [15:0] i_cfg_wdata = 16'h0000;
    logic [1:0]  i_cfg_be = 2'b00;
    logic        i_presence_notify_enable = 1'b1, i_wake_status = 1'b0;
    logic [3:0]  ev = 4'h0;     // fatal, non-fatal, correctable, wake message
    wire  [15:0] o_cfg_rdata, rdata2;
    wire         o_cfg_rvalid, o_presence_notify, o_wake_interrupt, o_syserr, rv2, serr2, wake2, note2;
    wire         i_oob_presence, i_retention_latch, i_power_fault, i_button_n, i_link_presence, i_slot_powered;
    int          n_checks = 0, n_mismatch = 0, n_serr = 0, n_wake = 0, n_note = 0, cyc = 0, base;
    always #10 i_clk = ~i_clk;
    psrc_card_model card (.i_clk, .o_oob_presence(i_oob_presence), .o_slot_powered(i_slot_powered),
        .o_retention_latch(i_retention_latch), .o_power_fault(i_power_fault), .o_button_n(i_button_n),
        .o_link_presence(i_link_presence));
    psrc_bank dut (.i_clk, .i_rst_n, .i_ce, .i_cfg_addr, .i_cfg_wr, .i_cfg_rd, .i_cfg_wdata, .i_cfg_be,
        .o_cfg_rdata, .o_cfg_rvalid, .i_oob_presence, .i_retention_latch, .i_power_fault, .i_button_n,
        .i_link_presence, .i_slot_powered, .i_presence_notify_enable, .i_wake_status, .i_wake_msg(ev[3]),
        .i_err_fatal(ev[0]), .i_err_nonfatal(ev[1]), .i_err_correctable(ev[2]), .o_presence_notify,
        .o_wake_interrupt, .o_syserr);
    // second port with no slot and no optional sensors fitted
    psrc_bank #(.SLOT_IMPL(0), .LATCH_IMPL(0), .FAULT_IMPL(0), .BUTTON_IMPL(0)) dut2 (.i_clk, .i_rst_n,
        .i_ce, .i_cfg_addr, .i_cfg_wr, .i_cfg_rd, .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata(rdata2),
        .o_cfg_rvalid(rv2), .i_oob_presence, .i_retention_latch, .i_power_fault, .i_button_n, .i_link_presence,
        .i_slot_powered, .i_presence_notify_enable, .i_wake_status, .i_wake_msg(ev[3]), .i_err_fatal(ev[0]),
        .i_err_nonfatal(ev[1]), .i_err_correctable(ev[2]), .o_presence_notify(note2),
        .o_wake_interrupt(wake2), .o_syserr(serr2));
    // ==========================================================
    // event pulse counters and hang guard
    always @(posedge i_clk) begin
        n_serr <= n_serr + (o_syserr === 1'b1) + (serr2 === 1'b1);
        n_wake <= n_wake + (o_wake_interrupt === 1'b1) + (wake2 === 1'b1);
        n_note <= n_note + (o_presence_notify === 1'b1) + (note2 === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge i_clk);
        i_cfg_addr <= a;
        i_cfg_wdata <= d;
        i_cfg_be <= be;
        i_cfg_wr <= 1'b1;
        @(posedge i_clk);
        i_cfg_wr <= 1'b0;
    endtask
    // the slotless port always shows presence and no flags on slot status
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_cfg_addr <= a;
        i_cfg_rd <= 1'b1;
        @(posedge i_clk);
        i_cfg_rd <= 1'b0;
        #1;
        chk({14'h0000, rv2, o_cfg_rvalid}, 16'h0003);
        chk(o_cfg_rdata, e);
        chk(rdata2, (a == `PSRC_OFF_SLOT_STATUS) ? 16'h0040 : e);
    endtask
    task automatic pulse(input int i);
        @(posedge i_clk);
        ev[i] <= 1'b1;
        @(posedge i_clk);
        ev[i] <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // test sequence
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(`PSRC_OFF_ROOT_CONTROL, 16'h0000);
        wr(`PSRC_OFF_SLOT_STATUS, 16'h000f, 2'b01);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0000);
        card.put(6'b100001);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0000);
        card.put(6'b101001);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0048);
        chk(16'(n_note), 16'h0001);
        wr(`PSRC_OFF_SLOT_STATUS, 16'h0008, 2'b00);
        wr(`PSRC_OFF_SLOT_STATUS, 16'h0000, 2'b01);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0048);
        wr(`PSRC_OFF_SLOT_STATUS, 16'hffb8, 2'b11);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0040);
        card.put(6'b111001);
        card.put(6'b110001);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0040);
        i_presence_notify_enable <= 1'b0;
        card.put(6'b000001);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0008);
        chk(16'(n_note), 16'h0001);
        $display("presence test done");
        card.put(6'b000110);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h000f);
        wr(`PSRC_OFF_SLOT_STATUS, 16'h000f, 2'b01);
        card.put(6'b000101);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0000);
        card.put(6'b000001);
        rd(`PSRC_OFF_SLOT_STATUS, 16'h0004);
        $display("slot event test done");
        wr(`PSRC_OFF_ROOT_CONTROL, 16'hffff, 2'b11);
        rd(`PSRC_OFF_ROOT_CONTROL, 16'h000f);
        rd(8'hb0, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(`PSRC_OFF_ROOT_CONTROL, 16'h0001 << i, 2'b01);
            base = n_serr;
            for (int j = 0; j < 3; j++) pulse(j);
            chk(16'(n_serr - base), 16'h0002);
        end
        i_ce <= 1'b0;
        base = n_serr;
        pulse(0);
        i_ce <= 1'b1;
        chk(16'(n_serr - base), 16'h0000);
        wr(`PSRC_OFF_ROOT_CONTROL, 16'h0000, 2'b01);
        base = n_wake;
        pulse(3);
        chk(16'(n_wake - base), 16'h0000);
        i_wake_status <= 1'b1;
        wr(`PSRC_OFF_ROOT_CONTROL, 16'h0008, 2'b01);
        wr(`PSRC_OFF_ROOT_CONTROL, 16'h0008, 2'b01);
        pulse(3);
        chk(16'(n_wake - base), 16'h0004);
        $display("root control test done");
        summarize();
    end
endmodule
`default_nettype wire
